// file: hia_user_terminal.sv
// user terminal end: automatic installation scan and configuration
//
// Overview of operation
// - transmitter ramps up 40 ms before bytes
// - transmitter ramps down 40 ms after bytes
// - unit decodes 0x70 all, 0x71-0x74 class
// - addresses 0x75-0x7F never used as class
// - pairing code: master id high, slave low
// - installed unit never holds slave id 0-7
// - same class units get distinct slave ids
// - non-auto unit uses preset id 0x80-0xFF
// - auto units get slave id 0x08-0x7F
// - each terminal has unique master id
// - new scan: 0x71-0x74, id 0-7, mid 0
// - new unit reports frequency, zero if none
// - allocated scan from 0x08, stop on silence
// - allocated unit reports its mid and frequency
// - config sends next free ids and parameters
// - unit applies config, replies with settings
// - bad or zero parameter keeps old value
// - clean config reply completes the pairing
//
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module hia_user_terminal #(
  parameter int RAMP_CYCLES = hia_pkg::RAMP_CYCLES_DEF,
  parameter int TIMEOUT_CYCLES = hia_pkg::TIMEOUT_CYCLES_DEF
) (
  input wire logic clock_i,
  input wire logic srst_i,
  hia_link_if.user_terminal link,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);
  import hia_pkg::*;

  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_UP = 3'b001,
    M_SEND = 3'b010,
    M_DOWN = 3'b011,
    M_WAIT = 3'b100,
    M_EVAL = 3'b101
  } hia_mstate_e;

  typedef enum logic [1:0] {
    PH_NEW = 2'b00,
    PH_ALLOC = 2'b01,
    PH_CONF = 2'b10
  } hia_phase_e;

  function automatic logic [1:0] class_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - ADDR_FIRST;
    return d[1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // register bus
  logic ack, next_ack;
  logic [31:0] rdata, next_rdata;
  logic [15:0] cfg_freq, next_cfg_freq;
  logic [7:0] cfg_settings, next_cfg_settings;
  logic [31:0] timeout, next_timeout;
  logic start;
  logic take;

  // scan state
  hia_mstate_e state, next_state;
  hia_phase_e phase, next_phase;
  logic [31:0] cnt, next_cnt;
  logic [7:0] cur_addr, next_cur_addr;
  logic [7:0] cur_sid, next_cur_sid;
  logic got, next_got;
  hia_rsp_s rsp_q, next_rsp_q;
  logic tgt_found, next_tgt_found;
  logic [7:0] tgt_addr, next_tgt_addr;
  logic [7:0] tgt_sid, next_tgt_sid;
  logic [7:0] free_mid, next_free_mid;
  logic [7:0] free_sid [4];
  logic [7:0] next_free_sid [4];
  logic done, next_done;
  logic conflict, next_conflict;
  logic ramp_end;

  // one wait cycle, then the answer on the following edge
  assign take = (avs_read_i || avs_write_i) && !ack;
  // writes land only at the completing edge, when waitrequest is low
  assign start = ack && avs_write_i && avs_address_i == REG_CTRL &&
                 avs_writedata_i[CTRL_START_POS];

  always_comb begin
    next_ack = take;
    next_rdata = rdata;
    next_cfg_freq = cfg_freq;
    next_cfg_settings = cfg_settings;
    next_timeout = timeout;
    if (ack && avs_write_i) begin
      case (avs_address_i)
        REG_CFG: begin
          next_cfg_freq = avs_writedata_i[15:0];
          next_cfg_settings = avs_writedata_i[23:16];
        end
        REG_TIMEOUT: next_timeout = avs_writedata_i;
        default: next_timeout = timeout;
      endcase
    end
    if (take && avs_read_i) begin
      case (avs_address_i)
        REG_CFG: next_rdata = {8'h00, cfg_settings, cfg_freq};
        REG_TIMEOUT: next_rdata = timeout;
        REG_STATUS: next_rdata = {tgt_sid, tgt_addr, free_mid, 4'h0, tgt_found,
                                  conflict, done, (state != M_IDLE)};
        REG_FREE: next_rdata = {free_sid[3], free_sid[2], free_sid[1], free_sid[0]};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
      cfg_freq <= VAL16_NONE;
      cfg_settings <= VAL8_NONE;
      timeout <= 32'(TIMEOUT_CYCLES);
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
      cfg_freq <= next_cfg_freq;
      cfg_settings <= next_cfg_settings;
      timeout <= next_timeout;
    end
  end

  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;
  assign avs_readdata_o = rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // installation sequencer
  assign ramp_end = (cnt == 32'(RAMP_CYCLES - 1));

  always_comb begin
    next_state = state;
    next_phase = phase;
    next_cnt = cnt;
    next_cur_addr = cur_addr;
    next_cur_sid = cur_sid;
    next_got = got;
    next_rsp_q = rsp_q;
    next_tgt_found = tgt_found;
    next_tgt_addr = tgt_addr;
    next_tgt_sid = tgt_sid;
    next_free_mid = free_mid;
    next_free_sid = free_sid;
    next_done = done;
    next_conflict = conflict;
    // a reply may land while our own ramp-down is still running
    if ((state == M_DOWN || state == M_WAIT) && link.rsp_valid && !got) begin
      next_got = 1'b1;
      next_rsp_q = link.rsp;
    end
    case (state)
      M_IDLE: begin
        if (start) begin
          next_phase = PH_NEW;
          next_cur_addr = ADDR_FIRST;
          next_cur_sid = SID_INST_FIRST;
          next_tgt_found = 1'b0;
          next_free_mid = MID_FIRST;
          for (int i = 0; i < 4; i++) begin
            next_free_sid[i] = SID_AUTO_FIRST;
          end
          next_done = 1'b0;
          next_conflict = 1'b0;
          next_cnt = '0;
          next_state = M_UP;
        end
      end
      M_UP: begin
        next_cnt = cnt + 32'd1;
        if (ramp_end) next_state = M_SEND;
      end
      M_SEND: begin
        next_got = 1'b0;
        next_cnt = '0;
        next_state = M_DOWN;
      end
      M_DOWN: begin
        next_cnt = cnt + 32'd1;
        if (ramp_end) begin
          next_cnt = '0;
          next_state = M_WAIT;
        end
      end
      M_WAIT: begin
        next_cnt = cnt + 32'd1;
        if (got || link.rsp_valid || cnt >= timeout) next_state = M_EVAL;
      end
      M_EVAL: begin
        next_cnt = '0;
        next_state = M_UP;
        case (phase)
          PH_NEW: begin
            if (got && !tgt_found) begin
              next_tgt_found = 1'b1;
              next_tgt_addr = cur_addr;
              next_tgt_sid = cur_sid;
            end
            if (cur_sid == SID_INST_LAST) begin
              next_cur_sid = SID_INST_FIRST;
              if (cur_addr == ADDR_LAST) begin
                next_phase = PH_ALLOC;
                next_cur_addr = ADDR_FIRST;
                next_cur_sid = SID_AUTO_FIRST;
              end else begin
                next_cur_addr = cur_addr + 8'h01;
              end
            end else begin
              next_cur_sid = cur_sid + 8'h01;
            end
          end
          PH_ALLOC: begin
            if (got && cur_sid != SID_AUTO_LAST) begin
              // used ids are skipped so the new pair is unique
              if (rsp_q.mid >= free_mid) next_free_mid = rsp_q.mid + 8'h01;
              next_free_sid[class_idx(cur_addr)] = cur_sid + 8'h01;
              next_cur_sid = cur_sid + 8'h01;
            end else if (cur_addr == ADDR_LAST) begin
              if (tgt_found) begin
                next_phase = PH_CONF;
                next_cur_addr = tgt_addr;
                next_cur_sid = tgt_sid;
              end else begin
                next_done = 1'b1;
                next_state = M_IDLE;
              end
            end else begin
              next_cur_addr = cur_addr + 8'h01;
              next_cur_sid = SID_AUTO_FIRST;
            end
          end
          default: begin
            // pairing holds only if the unit echoes the mid and sid that were sent
            next_done = 1'b1;
            next_conflict = !got || rsp_q.mid != free_mid ||
                            rsp_q.slave_ident != free_sid[class_idx(tgt_addr)];
            next_state = M_IDLE;
          end
        endcase
      end
      default: next_state = M_IDLE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state <= M_IDLE;
      phase <= PH_NEW;
      cnt <= '0;
      cur_addr <= ADDR_FIRST;
      cur_sid <= SID_INST_FIRST;
      got <= 1'b0;
      rsp_q <= '0;
      tgt_found <= 1'b0;
      tgt_addr <= ADDR_FIRST;
      tgt_sid <= SID_INST_FIRST;
      free_mid <= MID_FIRST;
      for (int i = 0; i < 4; i++) begin
        free_sid[i] <= SID_AUTO_FIRST;
      end
      done <= 1'b0;
      conflict <= 1'b0;
    end else begin
      state <= next_state;
      phase <= next_phase;
      cnt <= next_cnt;
      cur_addr <= next_cur_addr;
      cur_sid <= next_cur_sid;
      got <= next_got;
      rsp_q <= next_rsp_q;
      tgt_found <= next_tgt_found;
      tgt_addr <= next_tgt_addr;
      tgt_sid <= next_tgt_sid;
      free_mid <= next_free_mid;
      free_sid <= next_free_sid;
      done <= next_done;
      conflict <= next_conflict;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // link drive, all fields from registered state
  assign link.req_valid = (state == M_SEND);
  assign link.term_pwr = (state == M_UP) || (state == M_SEND) || (state == M_DOWN);
  assign link.req.addr = cur_addr;
  assign link.req.op = (phase == PH_CONF) ? HIA_OP_CONFIG : HIA_OP_STATUS;
  assign link.req.pin_mid = MID_INSTALL;
  assign link.req.pin_sid = cur_sid;
  assign link.req.new_mid = free_mid;
  assign link.req.new_sid = free_sid[class_idx(tgt_addr)];
  assign link.req.freq = cfg_freq;
  assign link.req.settings = cfg_settings;
endmodule // hia_user_terminal

// file: hia_pkg.sv
// shared constants and types for the install addressing link
package hia_pkg;
  // address byte classes
  localparam logic [7:0] ADDR_ALL = 8'h70;
  localparam logic [7:0] ADDR_FIRST = 8'h71;
  localparam logic [7:0] ADDR_LAST = 8'h74;
  localparam logic [7:0] ADDR_RSV_FIRST = 8'h75;
  localparam logic [7:0] ADDR_RSV_LAST = 8'h7e;
  localparam logic [7:0] ADDR_FUTURE = 8'h7f;
  // slave identifier ranges
  localparam logic [7:0] SID_INST_FIRST = 8'h00;
  localparam logic [7:0] SID_INST_LAST = 8'h07;
  localparam logic [7:0] SID_AUTO_FIRST = 8'h08;
  localparam logic [7:0] SID_AUTO_LAST = 8'h7f;
  localparam int SID_FIXED_POS = 7;
  localparam logic [7:0] MID_INSTALL = 8'h00;
  localparam logic [7:0] MID_FIRST = 8'h01;
  localparam logic [7:0] VAL8_NONE = 8'h00;
  localparam logic [15:0] VAL16_NONE = 16'h0000;
  // timing
  localparam int RAMP_TIME_MS = 40;
  localparam int CLK_FREQ_KHZ = 125000;
  localparam int RAMP_CYCLES_DEF = RAMP_TIME_MS * CLK_FREQ_KHZ;
  localparam int REPLY_TIMEOUT_MS = 100;
  localparam int TIMEOUT_CYCLES_DEF = REPLY_TIMEOUT_MS * CLK_FREQ_KHZ;
  // master register byte offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_CFG = 5'h04;
  localparam logic [4:0] REG_TIMEOUT = 5'h08;
  localparam logic [4:0] REG_STATUS = 5'h0c;
  localparam logic [4:0] REG_FREE = 5'h10;
  localparam int CTRL_START_POS = 0;

  typedef enum logic [1:0] {
    HIA_OP_NONE = 2'b00,
    HIA_OP_STATUS = 2'b01,
    HIA_OP_CONFIG = 2'b10
  } hia_op_e;

  typedef struct packed {
    logic [7:0] addr;
    hia_op_e op;
    logic [7:0] pin_mid;
    logic [7:0] pin_sid;
    logic [7:0] new_mid;
    logic [7:0] new_sid;
    logic [15:0] freq;
    logic [7:0] settings;
  } hia_req_s;

  typedef struct packed {
    logic [7:0] mid;
    logic [7:0] slave_ident;
    logic [15:0] freq;
    logic [7:0] settings;
  } hia_rsp_s;

  function automatic logic hia_is_unit_class(input logic [7:0] a);
    return (a >= ADDR_FIRST) && (a <= ADDR_LAST);
  endfunction

  function automatic logic hia_is_auto_sid(input logic [7:0] s);
    return (s >= SID_AUTO_FIRST) && (s <= SID_AUTO_LAST);
  endfunction
endpackage

// file: hia_link_if.sv
// message-level link between a user terminal and a headend unit
`timescale 1ns/10ps
interface hia_link_if;
  import hia_pkg::*;
  logic req_valid;
  hia_req_s req;
  logic term_pwr;
  logic rsp_valid;
  hia_rsp_s rsp;
  logic unit_pwr;

  modport user_terminal (
    output req_valid,
    output req,
    output term_pwr,
    input rsp_valid,
    input rsp,
    input unit_pwr
  );

  modport headend_unit (
    input req_valid,
    input req,
    input term_pwr,
    output rsp_valid,
    output rsp,
    output unit_pwr
  );
endinterface

// file: hia_headend_unit.sv
// headend unit end: address decode, pairing and configuration
`timescale 1ns/10ps
module hia_headend_unit #(
  parameter logic [7:0] UNIT_CLASS = 8'h71,
  parameter bit AUTO_INSTALL = 1'b1,
  parameter int RAMP_CYCLES = hia_pkg::RAMP_CYCLES_DEF
) (
  input wire logic clock_i,
  input wire logic srst_i,
  hia_link_if.headend_unit link,
  input wire logic preset_load_i,
  input wire logic [7:0] preset_sid_i,
  input wire logic [15:0] preset_freq_i,
  input wire logic [7:0] preset_settings_i,
  output logic [7:0] mid_o,
  output logic [7:0] sid_o,
  output logic [15:0] freq_o,
  output logic [7:0] settings_o,
  output logic installed_o
);
  import hia_pkg::*;

  typedef enum logic [1:0] {
    D_IDLE = 2'b00,
    D_UP = 2'b01,
    D_SEND = 2'b10,
    D_DOWN = 2'b11
  } hia_dstate_e;

  hia_dstate_e state, next_state;
  logic [31:0] cnt, next_cnt;
  logic [7:0] mid, next_mid;
  logic [7:0] slave_ident, next_sid;
  logic [15:0] freq, next_freq;
  logic [7:0] settings, next_settings;
  hia_rsp_s rsp, next_rsp;
  logic hit;
  logic ramp_end;

  // reserved and future codes never match a class
  assign hit = (link.req.addr == ADDR_ALL) || (link.req.addr == UNIT_CLASS);
  assign ramp_end = (cnt == 32'(RAMP_CYCLES - 1));

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_mid = mid;
    next_sid = slave_ident;
    next_freq = freq;
    next_settings = settings;
    next_rsp = rsp;
    case (state)
      D_IDLE: begin
        if (preset_load_i) begin
          next_freq = preset_freq_i;
          next_settings = preset_settings_i;
          if (AUTO_INSTALL) begin
            // fresh unit starts in the install range
            next_sid = {5'h00, preset_sid_i[2:0]};
            next_mid = MID_INSTALL;
          end else begin
            next_sid = preset_sid_i;
            next_sid[SID_FIXED_POS] = 1'b1;
          end
        end else if (link.req_valid && hit && link.req.pin_sid == slave_ident &&
                     (link.req.pin_mid == MID_INSTALL || link.req.pin_mid == mid)) begin
          if (link.req.op == HIA_OP_CONFIG) begin
            // zero or unusable values keep the old setting
            if (link.req.new_mid != VAL8_NONE) next_mid = link.req.new_mid;
            if (AUTO_INSTALL && hia_is_auto_sid(link.req.new_sid)) begin
              next_sid = link.req.new_sid;
            end
            if (link.req.freq != VAL16_NONE) next_freq = link.req.freq;
            if (link.req.settings != VAL8_NONE) begin
              next_settings = link.req.settings;
            end
          end
          if (link.req.op != HIA_OP_NONE && link.req.addr != ADDR_ALL) begin
            // broadcasts are applied silently to avoid reply collisions
            next_state = D_UP;
            next_cnt = '0;
          end
        end
        // status replies carry frequency and mid, zero when never set
        next_rsp.mid = next_mid;
        next_rsp.slave_ident = next_sid;
        next_rsp.freq = next_freq;
        next_rsp.settings = next_settings;
      end
      D_UP: begin
        next_cnt = cnt + 32'd1;
        if (ramp_end) next_state = D_SEND;
      end
      D_SEND: begin
        next_state = D_DOWN;
        next_cnt = '0;
      end
      D_DOWN: begin
        next_cnt = cnt + 32'd1;
        if (ramp_end) next_state = D_IDLE;
      end
      default: next_state = D_IDLE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state <= D_IDLE;
      cnt <= '0;
      mid <= MID_INSTALL;
      slave_ident <= AUTO_INSTALL ? SID_INST_FIRST : SID_AUTO_LAST + 8'h01;
      freq <= VAL16_NONE;
      settings <= VAL8_NONE;
      rsp <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      mid <= next_mid;
      slave_ident <= next_sid;
      freq <= next_freq;
      settings <= next_settings;
      rsp <= next_rsp;
    end
  end

  assign link.rsp_valid = (state == D_SEND);
  assign link.rsp = rsp;
  assign link.unit_pwr = (state != D_IDLE);
  assign mid_o = mid;
  assign sid_o = slave_ident;
  assign freq_o = freq;
  assign settings_o = settings;
  assign installed_o = (slave_ident > SID_INST_LAST);
endmodule // hia_headend_unit

// file: hia_props.sv
// concurrent checks on the link between the terminal and the unit
`timescale 1ns/10ps
module hia_props #(
  parameter int RAMP_CYCLES = 4,
  parameter logic [7:0] UNIT_CLASS = 8'h71
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic req_valid,
  input wire hia_pkg::hia_req_s req,
  input wire logic term_pwr,
  input wire logic rsp_valid,
  input wire hia_pkg::hia_rsp_s rsp,
  input wire logic unit_pwr
);
  import hia_pkg::*;
  logic [7:0] up_cnt;
  logic [7:0] next_up_cnt;
  hia_req_s last_req;
  hia_req_s next_last_req;
  logic hit;
  ////////////////////////////////////////////////////////////////////////////////
  // saturating count of transmit-on cycles, so a long wait cannot wrap into a match
  always_comb begin
    next_up_cnt = 8'h00;
    if (term_pwr && up_cnt != 8'hff) begin
      next_up_cnt = up_cnt + 8'h01;
    end else if (term_pwr) begin
      next_up_cnt = up_cnt;
    end
    next_last_req = req_valid ? req : last_req;
    hit = req_valid && (req.addr == UNIT_CLASS) && (req.op != HIA_OP_NONE);
  end
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      up_cnt <= 8'h00;
      last_req <= '0;
    end else begin
      up_cnt <= next_up_cnt;
      last_req <= next_last_req;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (srst_i);
  a_ramp_up_len: assert property (req_valid |-> up_cnt == RAMP_CYCLES[7:0])
    else $error("request sent without a full ramp-up");
  a_ramp_down_len: assert property (req_valid |-> ##RAMP_CYCLES term_pwr ##1 !term_pwr)
    else $error("terminal ramp-down length wrong");
  a_unit_pwr_span: assert property ($rose(unit_pwr) |-> ##RAMP_CYCLES (rsp_valid && unit_pwr)
    ##RAMP_CYCLES unit_pwr ##1 !unit_pwr)
    else $error("unit transmit window wrong");
  a_reply_cause: assert property (rsp_valid |-> $past(hit, RAMP_CYCLES + 1))
    else $error("reply without a request to this class");
  a_addr_class: assert property (req_valid |-> req.addr >= 8'h71 && req.addr <= 8'h74)
    else $error("request to a reserved or unused address");
  a_status_mid_zero: assert property (req_valid && req.op == HIA_OP_STATUS
    |-> req.pin_mid == 8'h00)
    else $error("status query with nonzero master id");
  a_cfg_ids_legal: assert property (req_valid && req.op == HIA_OP_CONFIG
    |-> req.new_sid inside {[8'h08:8'h7f]} && req.new_mid != 8'h00)
    else $error("config carries illegal identifiers");
  a_cfg_reply_echo: assert property (rsp_valid && last_req.op == HIA_OP_CONFIG
    |-> rsp.slave_ident == last_req.new_sid && rsp.mid == last_req.new_mid)
    else $error("config reply does not show assigned ids");
  a_status_reply_sid: assert property (rsp_valid && last_req.op == HIA_OP_STATUS
    |-> rsp.slave_ident == last_req.pin_sid)
    else $error("status reply from wrong slave id");
endmodule // hia_props

// file: hia_test.sv
// self-checking bench: one terminal and one unit joined by the link
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin error_cnt++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module hia_test;
  import hia_pkg::*;
  localparam int RAMP = 4;
  localparam int TMO = 3 * RAMP + 8;
  localparam logic [7:0] CLS = 8'h72;
  logic clock_i;
  logic srst_i;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic preset_load;
  logic [7:0] preset_sid;
  logic [15:0] preset_freq;
  logic [7:0] preset_settings;
  logic [7:0] mid;
  logic [7:0] slave_ident;
  logic [15:0] freq;
  logic [7:0] settings;
  logic installed;
  int error_cnt;
  int cmp_count;
  logic [31:0] seed;
  hia_link_if hia_link_if_i();
  hia_user_terminal #(.RAMP_CYCLES(RAMP), .TIMEOUT_CYCLES(TMO)) hia_user_terminal_i (
    .clock_i(clock_i), .srst_i(srst_i), .link(hia_link_if_i),
    .avs_address_i(avs_address), .avs_read_i(avs_read), .avs_write_i(avs_write),
    .avs_writedata_i(avs_writedata), .avs_readdata_o(avs_readdata),
    .avs_waitrequest_o(avs_waitrequest));
  hia_headend_unit #(.UNIT_CLASS(CLS), .AUTO_INSTALL(1'b1), .RAMP_CYCLES(RAMP))
  hia_headend_unit_i (
    .clock_i(clock_i), .srst_i(srst_i), .link(hia_link_if_i),
    .preset_load_i(preset_load), .preset_sid_i(preset_sid), .preset_freq_i(preset_freq),
    .preset_settings_i(preset_settings), .mid_o(mid), .sid_o(slave_ident), .freq_o(freq),
    .settings_o(settings), .installed_o(installed));
  hia_props #(.RAMP_CYCLES(RAMP), .UNIT_CLASS(CLS)) hia_props_i (
    .clock_i(clock_i), .srst_i(srst_i), .req_valid(hia_link_if_i.req_valid),
    .req(hia_link_if_i.req), .term_pwr(hia_link_if_i.term_pwr),
    .rsp_valid(hia_link_if_i.rsp_valid), .rsp(hia_link_if_i.rsp),
    .unit_pwr(hia_link_if_i.unit_pwr));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // status word: target sid, target class, next mid, flags done and found
  function automatic logic [31:0] exp_status(input logic found, input logic [7:0] nmid,
                                             input logic [7:0] tsid);
    return {tsid, CLS, nmid, 4'h0, found, 3'b010};
  endfunction
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // request held until the edge that sees waitrequest low, then released
  task automatic avs_xfer(input logic rd, input logic [4:0] a, input logic [31:0] d,
                          output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock_i);
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= d;
    @(posedge clock_i);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge clock_i);
      n++;
    end
    if (n >= 50) begin
      error_cnt++;
      $display("[FAIL] bus wait expected %h seen %h", 1'b0, avs_waitrequest);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic preset(input logic [7:0] s, input logic [15:0] f, input logic [7:0] g);
    @(posedge clock_i);
    preset_load <= 1'b1;
    preset_sid <= s;
    preset_freq <= f;
    preset_settings <= g;
    @(posedge clock_i);
    preset_load <= 1'b0;
    @(negedge clock_i);
    `CHK("preset sid", {5'b0, s[2:0]}, slave_ident)
    `CHK("installed", 1'b0, installed)
  endtask
  task automatic run_scan(output logic [31:0] st);
    int n;
    logic [31:0] q;
    n = 0;
    avs_xfer(1'b0, REG_CTRL, 32'h0000_0001, q);
    avs_xfer(1'b1, REG_STATUS, 32'h0000_0000, st);
    while (st[0] !== 1'b0 && n < 3000) begin
      avs_xfer(1'b1, REG_STATUS, 32'h0000_0000, st);
      n++;
    end
    if (n >= 3000) begin
      error_cnt++;
      $display("[FAIL] scan busy expected %h seen %h", 1'b0, st[0]);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  // a full scan runs some 1100 cycles; five scans fit well inside this span
  initial begin
    repeat (40000) @(posedge clock_i);
    error_cnt++;
    wrap_up();
  end
  initial begin
    logic [31:0] q;
    logic [31:0] st;
    logic [31:0] r;
    logic [31:0] c;
    error_cnt = 0;
    cmp_count = 0;
    seed = 32'h735d_d2b5;
    srst_i = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    preset_load = 1'b0;
    preset_sid = 8'h00;
    preset_freq = 16'h0000;
    preset_settings = 8'h00;
    repeat (16) @(posedge clock_i);
    srst_i <= 1'b0;
    @(negedge clock_i);
    `CHK("reset unit", 40'h0, {mid, slave_ident, freq, settings})
    avs_xfer(1'b1, REG_TIMEOUT, 32'h0000_0000, q);
    `CHK("timeout reg", TMO, q)
    avs_xfer(1'b0, 5'h14, 32'hffff_ffff, q);
    avs_xfer(1'b1, 5'h14, 32'h0000_0000, q);
    `CHK("unmapped", 32'h0000_0000, q)
    // zero parameters in the config keep the preset values
    r = xs();
    preset(r[7:0], r[23:8] | 16'h0001, r[31:24]);
    avs_xfer(1'b0, REG_CFG, 32'h0000_0000, q);
    run_scan(st);
    `CHK("status a", exp_status(1'b1, 8'h01, {5'b0, r[2:0]}), st)
    `CHK("unit ids", 16'h0108, {mid, slave_ident})
    `CHK("unit freq", r[23:8] | 16'h0001, freq)
    `CHK("unit settings", r[31:24], settings)
    `CHK("installed", 1'b1, installed)
    // rescan: the allocated unit answers at sid 8, sid 9 is silent
    run_scan(st);
    `CHK("status b", exp_status(1'b0, 8'h02, 8'h00) & 32'h0000_ffff, st & 32'h0000_ffff)
    avs_xfer(1'b1, REG_FREE, 32'h0000_0000, q);
    `CHK("free sids", 32'h0808_0908, q)
    `CHK("unit kept", 16'h0108, {mid, slave_ident})
    for (int i = 0; i < 3; i++) begin
      r = xs();
      c = xs();
      preset(r[7:0], r[23:8], r[31:24]);
      avs_xfer(1'b0, REG_CFG, {8'h00, c[23:16] | 8'h01, c[15:0] | 16'h0001}, q);
      run_scan(st);
      `CHK("flags c", 4'b1010, st[3:0])
      `CHK("sid c", 8'h08, slave_ident)
      `CHK("freq c", c[15:0] | 16'h0001, freq)
      `CHK("settings c", c[23:16] | 8'h01, settings)
    end
    wrap_up();
  end
endmodule // hia_test
